// ===== src/ssadc_pkg.sv
package ssadc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int NCH = 4;
    localparam int CNT_W = 12;
    localparam logic [11:0] CNT_CAP = 12'hfff;
    localparam int SYNC_W = 16;
    localparam int SYNC_WIDTH_DEF_NS = 2000;
    localparam logic [15:0] SYNC_WIDTH_RST =
        16'((SYNC_WIDTH_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] SYNC_MIN = 16'h0001;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_MODE = 6'h00;
    localparam logic [5:0] OFS_WIDTH = 6'h04;
    localparam logic [5:0] OFS_TRIM = 6'h08;
    localparam logic [5:0] OFS_CTRL = 6'h0c;
    localparam logic [5:0] OFS_RES_A = 6'h10;
    localparam logic [5:0] OFS_RES_B = 6'h14;
    localparam logic [5:0] OFS_RES_C = 6'h18;
    localparam logic [5:0] OFS_RES_AUX = 6'h1c;
    localparam logic [5:0] OFS_LAST = 6'h20;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] MODE_MASK = 8'h83;
    localparam int MODE_RATE_BIT = 7;
    localparam logic [2:0] TRIM_RST = 3'h0;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_FAULT_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SYNC = 2'b01,
        PH_CONV = 2'b10,
        PH_SHUT = 2'b11
    } ssadc_phase_e;
endpackage

// ===== src/ssadc_cnt_if.sv
`timescale 1ns/1ps
interface ssadc_cnt_if #(parameter int CW = 12);
    logic [CW-1:0] count;
    logic          running;
    logic          win_end;
    modport src (output count, output running, output win_end);
    modport cap (input count, input running, input win_end);
endinterface

// ===== src/ssadc_sync3.sv
`timescale 1ns/1ps
module ssadc_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         aclk,    // core clock
    input  wire logic         aresetn, // synchronous reset, low
    input  wire logic [W-1:0] d,       // asynchronous level
    output logic      [W-1:0] q        // settled level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit moves only while stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= RST;
        end else begin
            q_reg <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
        end
    end

    assign q = q_reg;
endmodule // ssadc_sync3

// ===== src/ssadc_capture.sv
`timescale 1ns/1ps
module ssadc_capture import ssadc_pkg::*; (
    input  wire logic        aclk,    // core clock
    input  wire logic        aresetn, // synchronous reset, low
    input  wire logic        trip,    // settled comparator level
    ssadc_cnt_if.cap         cnt,     // shared counter
    output logic [CNT_W-1:0] result   // captured count
);
    logic [CNT_W-1:0] result_reg;
    logic             done_reg;
    logic             take;

    // first trip of the window only; later chatter ignored
    assign take = cnt.running && trip && !done_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= '0;
        end else if (take) begin
            result_reg <= cnt.count;
        end else if (cnt.win_end && !done_reg) begin
            result_reg <= '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_reg <= 1'b0;
        end else if (cnt.win_end) begin
            done_reg <= 1'b0;
        end else if (take) begin
            done_reg <= 1'b1;
        end
    end

    assign result = result_reg;

    AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
        take |=> result == $past(cnt.count))
        else $error("trip did not capture the count");
    AST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt.win_end && !done_reg && !trip |=> result == '0)
        else $error("untripped channel not zeroed");
    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        done_reg && !cnt.win_end |=> $stable(result))
        else $error("result changed after capture");
endmodule // ssadc_capture

// ===== src/ssadc_top.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module ssadc_top import ssadc_pkg::*; (
    input  wire logic              aclk,               // core clock
    input  wire logic              aresetn,            // synchronous reset, low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,       // write address
    input  wire logic              s_axi_awvalid,      // write address valid
    output logic                   s_axi_awready,      // write address ready
    input  wire logic [31:0]       s_axi_wdata,        // write data
    input  wire logic [3:0]        s_axi_wstrb,        // byte enables
    input  wire logic              s_axi_wvalid,       // write data valid
    output logic                   s_axi_wready,       // write data ready
    output logic [1:0]             s_axi_bresp,        // write response
    output logic                   s_axi_bvalid,       // write response valid
    input  wire logic              s_axi_bready,       // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,       // read address
    input  wire logic              s_axi_arvalid,      // read address valid
    output logic                   s_axi_arready,      // read address ready
    output logic [31:0]            s_axi_rdata,        // read data
    output logic [1:0]             s_axi_rresp,        // read response
    output logic                   s_axi_rvalid,       // read data valid
    input  wire logic              s_axi_rready,       // read data ready
    input  wire logic              pwm_period_start,   // PWM cycle start pulse
    input  wire logic              pwm_fault_input_n,  // fault pin, low trips
    input  wire logic [NCH-1:0]    cmp_trip,           // comparators, aux on top
    output logic                   pwm_cycle_sync,     // ramp reset pulse
    output logic [1:0]             aux_select,         // aux selector drive
    output logic [2:0]             ramp_current_trim   // ramp current trim
);
    ssadc_cnt_if #(.CW(CNT_W)) cnt ();
    logic                aw_full_reg;
    logic                w_full_reg;
    logic [ADDR_W-1:0]   aw_addr_reg;
    logic [31:0]         w_data_reg;
    logic [3:0]          w_strb_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                rvalid_reg;
    logic [1:0]          rresp_reg;
    logic [31:0]         rdata_reg;
    logic                wr_fire;
    logic [ADDR_W-1:0]   wa;
    logic [ADDR_W-1:0]   ra;
    logic [31:0]         wmask;
    logic [31:0]         rd_word;
    logic [7:0]          mode_reg;
    logic [SYNC_W-1:0]   width_reg;
    logic [2:0]          trim_reg;
    logic                shut_reg;
    logic                restart;
    logic                fault_s;
    logic [NCH-1:0]      trip_s;
    logic [CNT_W-1:0]    res [NCH];
    ssadc_phase_e        phase_reg;
    ssadc_phase_e        phase_next;
    logic [SYNC_W-1:0]   sync_cnt_reg;
    logic [SYNC_W-1:0]   load_w;
    logic                sync_out_reg;
    logic [CNT_W-1:0]    count_reg;
    logic [CNT_W-1:0]    last_reg;
    logic                half_reg;
    logic                cnt_step;
    logic [SYNC_W-1:0]   hlen_reg;
    logic [SYNC_W-1:0]   hwid_reg;
    function automatic logic ssadc_hit(input logic [ADDR_W-1:0] a);
        ssadc_hit = (a <= OFS_LAST);
    endfunction
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wa = {aw_addr_reg[ADDR_W-1:2], 2'b00};
    assign ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= ssadc_hit(wa) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (ra == OFS_MODE) begin
            rd_word[7:0] = mode_reg;
        end else if (ra == OFS_WIDTH) begin
            rd_word[SYNC_W-1:0] = width_reg;
        end else if (ra == OFS_TRIM) begin
            rd_word[2:0] = trim_reg;
        end else if (ra == OFS_CTRL) begin
            rd_word[CTRL_RESTART_BIT] = shut_reg;
            rd_word[CTRL_FAULT_BIT] = fault_s;
        end else if (ra == OFS_RES_A) begin
            rd_word[CNT_W-1:0] = res[0];
        end else if (ra == OFS_RES_B) begin
            rd_word[CNT_W-1:0] = res[1];
        end else if (ra == OFS_RES_C) begin
            rd_word[CNT_W-1:0] = res[2];
        end else if (ra == OFS_RES_AUX) begin
            rd_word[CNT_W-1:0] = res[3];
        end else if (ra == OFS_LAST) begin
            rd_word[CNT_W-1:0] = last_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= ssadc_hit(ra) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= MODE_RST;
        end else if (wr_fire && wa == OFS_MODE) begin
            mode_reg <= (mode_reg & ~wmask[7:0]) | (w_data_reg[7:0] & wmask[7:0] & MODE_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            width_reg <= SYNC_WIDTH_RST;
        end else if (wr_fire && wa == OFS_WIDTH) begin
            width_reg <= (width_reg & ~wmask[SYNC_W-1:0]) | (w_data_reg[SYNC_W-1:0] & wmask[SYNC_W-1:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_reg <= TRIM_RST;
        end else if (wr_fire && wa == OFS_TRIM && w_strb_reg[0]) begin
            trim_reg <= w_data_reg[2:0];
        end
    end

    // fourth comparator sits behind this selector; mains are hard-wired
    assign aux_select = mode_reg[1:0];
    assign ramp_current_trim = trim_reg;
    assign restart = wr_fire && wa == OFS_CTRL && w_strb_reg[0] && w_data_reg[CTRL_RESTART_BIT];
    ssadc_sync3 #(.W(1), .RST(1'b1)) u_fault_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pwm_fault_input_n),
        .q       (fault_s)
    );
    ssadc_sync3 #(.W(NCH), .RST('0)) u_trip_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (cmp_trip),
        .q       (trip_s)
    );

    // fault wins over a restart in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shut_reg <= 1'b0;
        end else if (!fault_s) begin
            shut_reg <= 1'b1;
        end else if (restart) begin
            shut_reg <= 1'b0;
        end
    end

    assign load_w = (width_reg == '0) ? SYNC_MIN : width_reg;
    // each accepted period start ends a window; in double update mode the
    // PWM gives one per half period, so the window halves with it
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_IDLE: begin
                if (shut_reg) phase_next = PH_SHUT;
                else if (pwm_period_start) phase_next = PH_SYNC;
            end
            PH_SYNC: begin
                if (shut_reg) phase_next = PH_SHUT;
                else if (sync_cnt_reg == SYNC_MIN) phase_next = PH_CONV;
            end
            PH_CONV: begin
                if (shut_reg) phase_next = PH_SHUT;
                else if (pwm_period_start) phase_next = PH_SYNC;
            end
            PH_SHUT: begin
                if (!shut_reg) phase_next = PH_IDLE;
            end
            default: phase_next = PH_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_cnt_reg <= '0;
        end else if (phase_next == PH_SYNC && phase_reg != PH_SYNC) begin
            sync_cnt_reg <= load_w;
        end else if (phase_reg == PH_SYNC) begin
            sync_cnt_reg <= sync_cnt_reg - SYNC_MIN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_out_reg <= 1'b0;
        end else begin
            sync_out_reg <= (phase_next == PH_SYNC);
        end
    end

    assign pwm_cycle_sync = sync_out_reg;
    // slow rate: step on every other edge of the window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_reg <= 1'b0;
        end else if (phase_next != PH_CONV) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= !half_reg;
        end
    end

    assign cnt_step = (phase_reg == PH_CONV) && (mode_reg[MODE_RATE_BIT] || half_reg) && count_reg != CNT_CAP;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
        end else if (phase_next != PH_CONV) begin
            count_reg <= '0;
        end else if (cnt_step) begin
            count_reg <= count_reg + 12'h001;
        end
    end
    // highest count reached in the last window, a guide for calibration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_reg <= '0;
        end else if (cnt.win_end) begin
            last_reg <= count_reg;
        end
    end
    assign cnt.count   = count_reg;
    assign cnt.running = (phase_reg == PH_CONV);
    assign cnt.win_end = (phase_reg == PH_CONV) && (shut_reg || pwm_period_start);
    // one counter and one ramp serve all four channels at once
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            ssadc_capture u_cap (
                .aclk    (aclk),
                .aresetn (aresetn),
                .trip    (trip_s[gi]),
                .cnt     (cnt),
                .result  (res[gi])
            );
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hlen_reg <= '0;
            hwid_reg <= '0;
        end else if (phase_next == PH_SYNC && phase_reg != PH_SYNC) begin
            hlen_reg <= '0;
            hwid_reg <= load_w;
        end else if (sync_out_reg) begin
            hlen_reg <= hlen_reg + SYNC_MIN;
        end
    end

    AST_AUX_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wa == OFS_MODE && w_strb_reg[0] |=> aux_select == $past(w_data_reg[1:0]))
        else $error("aux select does not follow mode write");
    AST_TRIM: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wa == OFS_TRIM && w_strb_reg[0] |=> ramp_current_trim == $past(w_data_reg[2:0]))
        else $error("trim does not follow write");
    AST_SYNC_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(pwm_cycle_sync) && phase_reg == PH_CONV |-> hlen_reg == hwid_reg && count_reg == '0)
        else $error("sync pulse width wrong");
    AST_SYNC_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        pwm_cycle_sync |-> count_reg == '0 && !cnt.running)
        else $error("counter not held at zero during sync");
    AST_RATE_HALF: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_step && !mode_reg[MODE_RATE_BIT] ##1 !mode_reg[MODE_RATE_BIT] |-> !cnt_step)
        else $error("half rate counter stepped twice in a row");
    AST_RATE_FULL: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt.running && mode_reg[MODE_RATE_BIT] && count_reg != CNT_CAP && phase_next == PH_CONV
        |=> count_reg == $past(count_reg) + 12'h001)
        else $error("full rate counter missed a step");
    AST_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
        count_reg == CNT_CAP && phase_next == PH_CONV |=> count_reg == CNT_CAP)
        else $error("counter passed its cap");
    AST_SHUT: assert property (@(posedge aclk) disable iff (!aresetn)
        shut_reg |=> !pwm_cycle_sync && !cnt.running)
        else $error("sync or conversion during shutdown");
    AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
        !fault_s |=> shut_reg [*2])
        else $error("fault did not hold shutdown");

    COV_WINDOW: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(pwm_cycle_sync) ##[1:1000] cnt.win_end);
    COV_CAPPED: cover property (@(posedge aclk) disable iff (!aresetn)
        count_reg == CNT_CAP);
    COV_SHUT: cover property (@(posedge aclk) disable iff (!aresetn)
        cnt.running ##1 shut_reg ##[1:50] !shut_reg);
endmodule // ssadc_top

// ===== dv/ssadc_far_model.sv
`timescale 1ns/1ps
module ssadc_far_model (
    input  wire logic        aclk,    // core clock
    input  wire logic        aresetn, // reset, low
    input  wire logic        run,     // pwm running
    input  wire logic [15:0] period,  // cycles per pwm cycle
    input  wire logic [63:0] thr,     // crossing time at trim 0, per channel
    input  wire logic [2:0]  trim,    // ramp current trim
    input  wire logic        sync,    // ramp reset pulse
    output logic             start,   // pwm cycle start
    output logic [3:0]       trip     // comparator levels
);
    logic [15:0] pcnt_reg;
    logic [15:0] ramp_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            pcnt_reg <= 16'h0000;
            start    <= 1'b0;
        end else begin
            pcnt_reg <= (pcnt_reg == period - 16'h0001) ? 16'h0000 : pcnt_reg + 16'h0001;
            start    <= pcnt_reg == period - 16'h0001;
        end
    end
    // capacitor held discharged while the pulse is high
    always_ff @(posedge aclk) begin
        if (!aresetn || sync) ramp_reg <= 16'h0000;
        else if (ramp_reg != 16'hffff) ramp_reg <= ramp_reg + 16'h0001;
    end
    // one ramp for all channels; more current crosses sooner
    always_comb begin
        for (int i = 0; i < 4; i++)
            trip[i] = !sync && 32'(ramp_reg) * (32'h8 + 32'(trim)) >= 32'(thr[i*16+:16]) * 32'h8;
    end
endmodule // ssadc_far_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top import ssadc_pkg::*;;
    logic        aclk = 1'b0, aresetn = 1'b0, fault_n = 1'b1, run = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [15:0] period = 16'h012c;
    logic [63:0] thr = {16'h00f0, 16'hffff, 16'h0096, 16'h0028};
    logic        awready, wready, bvalid, arready, rvalid, sync, start;
    logic [1:0]  bresp, rresp, rr, aux_sel;
    logic [2:0]  trim;
    logic [3:0]  trip;
    int          num_errors = 0, total_checks = 0, cyc = 0;

    ssadc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_period_start(start),
        .pwm_fault_input_n(fault_n), .cmp_trip(trip), .pwm_cycle_sync(sync), .aux_select(aux_sel),
        .ramp_current_trim(trim));
    ssadc_far_model far_u (.aclk(aclk), .aresetn(aresetn), .run(run), .period(period), .thr(thr),
        .trim(trim), .sync(sync), .start(start), .trip(trip));

    initial begin
        forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // length of the next ramp reset pulse, 0 if none within two periods
    task automatic plen(output int n);
        n = 0;
        for (int i = 0; i < 2 * period && sync !== 1'b1; i++) @(negedge aclk);
        while (sync === 1'b1) begin
            n++;
            @(negedge aclk);
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        rd(OFS_TRIM, d);
        chk(d, 32'(TRIM_RST));
        rd(OFS_WIDTH, d);
        chk(d, 32'(SYNC_WIDTH_RST));
        for (int i = 0; i < 4; i++) begin
            wr(OFS_MODE, 32'(i), RESP_OKAY);
            @(negedge aclk);
            chk(32'(aux_sel), 32'(i));
        end
        wr(OFS_MODE, 32'hffff_ffff, RESP_OKAY);
        rd(OFS_MODE, d);
        chk(d, 32'h0000_0083);
        wr(OFS_TRIM, 32'hffff_ffff, RESP_OKAY);
        rd(OFS_TRIM, d);
        chk(d, 32'h0000_0007);
        chk(32'(trim), 32'h0000_0007);
        wr(OFS_TRIM, 32'h0000_0000, RESP_OKAY);
        wr(6'h3c, 32'h0000_0001, RESP_SLVERR);
        rd(6'h3c, d);
        chk(32'(rr), 32'(RESP_SLVERR));
    endtask
    task automatic t_conv(input logic full);
        logic [31:0] d, k;
        wr(OFS_MODE, {24'h00_0000, full, 7'h00}, RESP_OKAY);
        repeat (3 * period) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_RES_A + 6'(4 * i), d);
            k = 32'(thr[i*16+:16]) >> !full;
            if (thr[i*16+:16] == 16'hffff) chk(d, 32'h0000_0000);
            else chk_in(d, k, k + 5);
        end
        rd(OFS_LAST, d);
        k = 32'(period - 16'h0004) >> !full;
        chk_in(d, k - 4, k);
    endtask
    task automatic t_sync();
        logic [31:0] d;
        int n;
        plen(n);
        chk(32'(n), 32'h0000_0004);
        @(posedge aclk);
        fault_n <= 1'b0;
        repeat (10) @(posedge aclk);
        plen(n);
        chk(32'(n), 32'h0000_0000);
        rd(OFS_CTRL, d);
        chk(d, 32'h0000_0001);
        fault_n <= 1'b1;
        repeat (10) @(posedge aclk);
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        plen(n);
        chk(32'(n), 32'h0000_0004);
    endtask
    // software trim search against the reference channel
    task automatic t_cal();
        logic [31:0] d, tgt;
        logic [2:0] tv;
        tgt = 32'(period - 16'h0004) * 5 / 7;
        tv = 3'h0;
        wr(OFS_MODE, 32'h0000_0083, RESP_OKAY);
        forever begin
            wr(OFS_TRIM, 32'(tv), RESP_OKAY);
            repeat (3 * period) @(posedge aclk);
            rd(OFS_RES_AUX, d);
            if (d < tgt || tv == 3'h7) break;
            tv++;
        end
        chk(32'(tv), 32'h0000_0002);
        chk(32'(trim), 32'h0000_0002);
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        wr(OFS_WIDTH, 32'h0000_0004, RESP_OKAY);
        run <= 1'b1;
        t_conv(1'b1);
        t_conv(1'b0);
        t_sync();
        t_cal();
        test_done();
    end
endmodule // tb_top
